// ==== hw/ogc_pkg.sv ====
// Constants shared by the offset and gain calibration stage.
// Assumes a byte-wide register port and 24-bit signed filter samples.
package ogc_pkg;
    localparam int SAMPLE_W = 24;
    localparam int GAIN_FRAC_BITS = 22;
    localparam logic [7:0] ADDR_OFF_HI = 8'h21;
    localparam logic [7:0] ADDR_OFF_MID = 8'h22;
    localparam logic [7:0] ADDR_OFF_LO = 8'h23;
    localparam logic [7:0] ADDR_GAIN_COEF_HIGH_BYTE = 8'h24;
    localparam logic [7:0] ADDR_GAIN_MID = 8'h25;
    localparam logic [7:0] ADDR_GAIN_COEF_LOW_BYTE = 8'h26;
    localparam logic [7:0] OFF_RESET = 8'h00;
    localparam logic [7:0] GAIN_RESET = 8'h00;
    localparam logic [23:0] FACTORY_GAIN = 24'h555555;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int FIFO_DEPTH = 4;
endpackage

// ==== hw/ogc_top.sv ====
// Offset and gain calibration stage with its output FIFO.
// Assumes one clock mclk, an asynchronous active-high reset, and a register port driven by the serial control logic.
`timescale 1ns/1ns

module ogc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } ogc_fifo_state_t;
    ogc_fifo_state_t st;
    ogc_fifo_state_t next_st;
    logic push;
    logic pop;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("FIFO depth must be a power of two of at least two.");
        end
    end

    assign in_ready = st.cnt != (AW + 1)'(DEPTH);
    assign out_valid = st.cnt != '0;
    assign out_data = st.mem[st.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

module ogc_top #(
    parameter logic [23:0] FACTORY_GAIN = ogc_pkg::FACTORY_GAIN,
    parameter int DEPTH = ogc_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic [23:0] sample_in,
    output logic sample_ready,
    output logic cal_valid,
    output logic [23:0] cal_data,
    input wire logic cal_ready
);
    typedef struct packed {
        logic [23:0] off;
        logic [23:0] gain;
        logic loaded;
        logic in_rdy;
        logic s_valid;
        logic [23:0] s_data;
        logic o_valid;
        logic [23:0] o_data;
        logic [7:0] rdata;
    } ogc_state_t;
    ogc_state_t st;
    ogc_state_t next_st;
    logic f_in_ready;
    logic f_out_valid;
    logic [23:0] f_out_data;
    logic f_pop;
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [27:0] scaled;
    logic [23:0] result;

    initial begin
        if (DEPTH < 2) begin
            $error("Output FIFO needs at least two words.");
        end
    end

    // The offset is taken off before scaling, so its weight follows the gain.
    assign diff = 25'(signed'(sample_in)) - 25'(signed'(st.off));
    assign prod = 50'(diff) * 50'(signed'({1'b0, st.gain}));
    // Rounding to nearest gives minus 133 for one hundred offset counts at nominal gain; flooring gives minus 134.
    assign scaled = 28'((prod + (50'sd1 <<< (ogc_pkg::GAIN_FRAC_BITS - 1)))
        >>> ogc_pkg::GAIN_FRAC_BITS);

    always_comb begin
        if (scaled > 28'sh07fffff) begin
            result = 24'h7fffff;
        end else if (scaled < -28'sh0800000) begin
            result = 24'h800000;
        end else begin
            result = scaled[23:0];
        end
    end

    assign f_pop = !st.o_valid || cal_ready;

    ogc_fifo #(.WIDTH(ogc_pkg::SAMPLE_W), .DEPTH(DEPTH)) u_fifo (
        .clk(mclk),
        .rst(rst),
        .in_valid(st.s_valid),
        .in_ready(f_in_ready),
        .in_data(st.s_data),
        .out_valid(f_out_valid),
        .out_ready(f_pop),
        .out_data(f_out_data)
    );

    always_comb begin
        next_st = st;
        // Factory gain is a constant fuse image, so it is copied in on the first clock after reset.
        if (!st.loaded) begin
            next_st.gain = FACTORY_GAIN;
            next_st.loaded = 1'b1;
        end else if (reg_wr) begin
            unique case (reg_addr)
                ogc_pkg::ADDR_OFF_HI: next_st.off[23:16] = reg_wdata;
                ogc_pkg::ADDR_OFF_MID: next_st.off[15:8] = reg_wdata;
                ogc_pkg::ADDR_OFF_LO: next_st.off[7:0] = reg_wdata;
                ogc_pkg::ADDR_GAIN_COEF_HIGH_BYTE: next_st.gain[23:16] = reg_wdata;
                ogc_pkg::ADDR_GAIN_MID: next_st.gain[15:8] = reg_wdata;
                ogc_pkg::ADDR_GAIN_COEF_LOW_BYTE: next_st.gain[7:0] = reg_wdata;
                default: next_st.off = st.off;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                ogc_pkg::ADDR_OFF_HI: next_st.rdata = st.off[23:16];
                ogc_pkg::ADDR_OFF_MID: next_st.rdata = st.off[15:8];
                ogc_pkg::ADDR_OFF_LO: next_st.rdata = st.off[7:0];
                ogc_pkg::ADDR_GAIN_COEF_HIGH_BYTE: next_st.rdata = st.gain[23:16];
                ogc_pkg::ADDR_GAIN_MID: next_st.rdata = st.gain[15:8];
                ogc_pkg::ADDR_GAIN_COEF_LOW_BYTE: next_st.rdata = st.gain[7:0];
                default: next_st.rdata = ogc_pkg::UNMAPPED_READ;
            endcase
        end
        if (st.s_valid && f_in_ready) begin
            next_st.s_valid = 1'b0;
        end
        // Half rate at the input keeps sample_ready a plain flip-flop; the filter is far slower anyway.
        if (sample_valid && st.in_rdy) begin
            next_st.s_valid = 1'b1;
            next_st.s_data = result;
        end
        next_st.in_rdy = !next_st.s_valid && next_st.loaded;
        if (f_pop) begin
            next_st.o_valid = f_out_valid;
            next_st.o_data = f_out_data;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.off <= {3{ogc_pkg::OFF_RESET}};
            st.gain <= {3{ogc_pkg::GAIN_RESET}};
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign sample_ready = st.in_rdy;
    assign cal_valid = st.o_valid;
    assign cal_data = st.o_data;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Reference for the result check, formed as two products so it does not share the datapath's form.
    function automatic logic [23:0] sat_ref(input logic [23:0] s, input logic [23:0] o, input logic [23:0] g);
        logic signed [49:0] full;
        full = (50'(signed'(s)) * 50'(signed'({1'b0, g})) - 50'(signed'(o)) * 50'(signed'({1'b0, g}))
            + (50'sd1 <<< (ogc_pkg::GAIN_FRAC_BITS - 1))) >>> ogc_pkg::GAIN_FRAC_BITS;
        if (full > 50'sh7fffff) begin
            return 24'h7fffff;
        end
        if (full < -50'sh800000) begin
            return 24'h800000;
        end
        return full[23:0];
    endfunction

    sequence wr_at(logic [7:0] a);
        reg_wr && st.loaded && reg_addr == a;
    endsequence

    offset_high_byte_a: assert property (wr_at(ogc_pkg::ADDR_OFF_HI) |=> st.off[23:16] == $past(reg_wdata))
        else $error("Offset high byte not stored.");
    offset_mid_byte_a: assert property (wr_at(ogc_pkg::ADDR_OFF_MID) |=> st.off[15:8] == $past(reg_wdata))
        else $error("Offset middle byte not stored.");
    offset_low_byte_a: assert property (wr_at(ogc_pkg::ADDR_OFF_LO) |=> st.off[7:0] == $past(reg_wdata))
        else $error("Offset low byte not stored.");
    gain_high_byte_a: assert property (wr_at(ogc_pkg::ADDR_GAIN_COEF_HIGH_BYTE) |=> st.gain[23:16] == $past(reg_wdata))
        else $error("Gain high byte not stored.");
    gain_low_bytes_a: assert property ((wr_at(ogc_pkg::ADDR_GAIN_MID) |=> st.gain[15:8] == $past(reg_wdata))
        and (wr_at(ogc_pkg::ADDR_GAIN_COEF_LOW_BYTE) |=> st.gain[7:0] == $past(reg_wdata)))
        else $error("Gain lower bytes not stored.");
    factory_gain_load_a: assert property ($rose(st.loaded) |-> st.gain == FACTORY_GAIN)
        else $error("Factory gain not loaded.");
    offset_readback_a: assert property (reg_rd && reg_addr == ogc_pkg::ADDR_OFF_HI
        |=> reg_rdata == $past(st.off[23:16]))
        else $error("Offset high byte read back wrong.");
    user_gain_used_a: assert property (wr_at(ogc_pkg::ADDR_GAIN_COEF_HIGH_BYTE) ##1 (sample_valid && st.in_rdy && !reg_wr)
        |-> prod == 50'(diff) * 50'(signed'({1'b0, $past(reg_wdata), st.gain[15:0]})))
        else $error("Written gain not used.");
    cal_result_a: assert property (sample_valid && st.in_rdy
        |=> st.s_valid && st.s_data == sat_ref($past(sample_in), $past(st.off), $past(st.gain)))
        else $error("Calibrated sample wrong.");
endmodule

// ==== tb/ogc_bench.sv ====
// Bench for the calibration stage: register defaults, a table of calibrated samples, back-pressure and reset.
// Assumes ogc_top takes every request on a rising edge of mclk and drives registered outputs.
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; $display("mismatch at %0t: %h not %h", $time, (a), (b)); end end
module offset_gain_calibration_bench;
    typedef struct {logic [23:0] off; logic [23:0] gain; logic [23:0] smp; logic [23:0] want;} ogc_row_t;
    logic mclk, rst, reg_wr, reg_rd, sample_valid, cal_ready, sample_ready, cal_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [23:0] sample_in, cal_data, off, gain;
    logic [23:0] q[$];
    int num_errors = 0;
    int cmp_count = 0;
    bit ok;
    ogc_row_t rows [6] = '{
        '{24'h000000, 24'h555555, 24'h0003e8, 24'h000535},
        '{24'h000064, 24'h555555, 24'h000000, 24'hffff7b},
        '{24'hfffffb, 24'h400000, 24'h00000a, 24'h00000f},
        '{24'h000064, 24'h2aaaaa, 24'h000000, 24'hffffbd},
        '{24'h000000, 24'hffffff, 24'h7fffff, 24'h7fffff},
        '{24'h000001, 24'hffffff, 24'h800000, 24'h800000}};
    ogc_top u_ogc_top (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .sample_in(sample_in),
        .sample_ready(sample_ready), .cal_valid(cal_valid), .cal_data(cal_data), .cal_ready(cal_ready));
    initial begin
        mclk = 0;
        forever #25 mclk = ~mclk;
    end
    task automatic tick();
        @(posedge mclk);
        #2;
    endtask
    task automatic tally_and_finish();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // A wait that runs out is a fault unless the caller expects a refusal.
    task automatic wait_for(input bit on_cal, output bit got);
        got = 0;
        for (int i = 0; i < 20 && !got; i++) begin
            got = on_cal ? (cal_valid === 1'b1) : (sample_ready === 1'b1);
            if (!got) tick();
        end
    endtask
    // Strobes stay up between transfers of one kind; the next task of another kind lowers them.
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_rd = 0;
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        tick();
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 0;
        reg_rd = 1;
        reg_addr = a;
        tick();
        `CHK(reg_rdata, d)
    endtask
    function automatic logic [23:0] model(logic [23:0] s);
        longint p;
        p = (((longint'($signed(s)) - longint'($signed(off))) * longint'(gain)) + (64'sd1 <<< 21)) >>> 22;
        if (p > 64'sh7fffff) return 24'h7fffff;
        if (p < -64'sh800000) return 24'h800000;
        return p[23:0];
    endfunction
    task automatic push(input logic [23:0] s, output bit got);
        wait_for(0, got);
        if (got) begin
            reg_wr = 0;
            reg_rd = 0;
            sample_valid = 1;
            sample_in = s;
            tick();
            sample_valid = 0;
        end
    endtask
    task automatic expect_out(input logic [23:0] e);
        bit got;
        wait_for(1, got);
        if (!got) begin
            num_errors++;
            tally_and_finish();
        end else begin
            `CHK(cal_data, e)
        end
        tick();
    endtask
    task automatic defaults();
        rst = 1;
        repeat (10) tick();
        `CHK(reg_rdata, 8'h00)
        `CHK(cal_valid, 1'b0)
        rst = 0;
        repeat (2) tick();
        off = 0;
        gain = ogc_pkg::FACTORY_GAIN;
        reg_read(8'h21, 8'h00);
        reg_read(8'h22, 8'h00);
        reg_read(8'h23, 8'h00);
        reg_read(8'h24, 8'h55);
        reg_read(8'h25, 8'h55);
        reg_read(8'h26, 8'h55);
        reg_read(8'h27, 8'h00);
    endtask
    initial begin
        {reg_wr, reg_rd, sample_valid, reg_addr, reg_wdata, sample_in} = '0;
        cal_ready = 1;
        defaults();
        foreach (rows[i]) begin
            off = rows[i].off;
            gain = rows[i].gain;
            for (int b = 0; b < 3; b++) begin
                reg_write(8'h21 + 8'(b), off[23 - 8 * b -: 8]);
                reg_write(8'h24 + 8'(b), gain[23 - 8 * b -: 8]);
            end
            reg_read(8'h24, gain[23:16]);
            reg_read(8'h23, off[7:0]);
            reg_write(8'h24, gain[23:16]);
            push(rows[i].smp, ok);
            `CHK(ok, 1'b1)
            expect_out(rows[i].want);
        end
        // With the sink stalled the FIFO must fill and then refuse.
        cal_ready = 0;
        for (int k = 0; k < 8; k++) begin
            push(24'(k * 5), ok);
            if (ok) q.push_back(24'(k * 5));
        end
        `CHK(q.size(), ogc_pkg::FIFO_DEPTH + 2)
        `CHK(sample_ready, 1'b0)
        cal_ready = 1;
        foreach (q[i]) expect_out(model(q[i]));
        tick();
        `CHK(cal_valid, 1'b0)
        defaults();
        tally_and_finish();
    end
endmodule
